// ==== rtl/usbep_defs.svh ====
`ifndef USBEP_DEFS_SVH
`define USBEP_DEFS_SVH

// ==========================================
// register indices, byte address is index * 4
`define USBEP_IDX_CSRH0      10'h103
`define USBEP_IDX_COUNT0     10'h108
`define USBEP_IDX_TYPE0      10'h10A
`define USBEP_IDX_NAK_FRAME_LIMIT     10'h10B
`define USBEP_IDX_INT_STAT   10'h10C
`define USBEP_IDX_INT_CLR    10'h10D
`define USBEP_IDX_INT_EN     10'h10E

// ==========================================
// field positions
`define USBEP_CSRH0_FLUSH    0
`define USBEP_CSRH0_TOGGLE   1
`define USBEP_CSRH0_TWE      2
`define USBEP_SPEED_LSB      6
`define USBEP_SPEED_MSB      7
`define USBEP_NAK_FRAME_LIMIT_MSB     4
`define USBEP_INT_NAK_TO     0
`define USBEP_INT_FLUSH      1
`define USBEP_INT_COUNT      2

// ==========================================
// reset values
`define USBEP_RST_SPEED      2'h0
`define USBEP_RST_NAK_FRAME_LIMIT     5'h00
`define USBEP_RST_COUNT      7'h00

// ==========================================
// nak limit decode
`define USBEP_NAK_FRAME_LIMIT_MIN     5'h02
`define USBEP_NAK_FRAME_LIMIT_MAX     5'h10

`endif

// ==== rtl/usbep_pkg.sv ====
package usbep_pkg;

   // ==========================================
   // target speed codes, 0 and 1 reserved
   typedef enum logic [1:0] {
      USBEP_SPEED_FULL = 2'h2,
      USBEP_SPEED_LOW  = 2'h3
   } usbep_speed_t;

endpackage

// ==== rtl/usbep_nak_timer.sv ====
`timescale 1ns/1ps
`include "usbep_defs.svh"

module usbep_nak_timer #(
   parameter int CW = 17
) (
   input  wire logic          pclk,        // system clock
   input  wire logic          presetn,     // async reset, low
   input  wire logic          enable,      // host mode and limit valid
   input  wire logic [4:0]    limit_m,     // nak limit setting
   input  wire logic          frame_start, // frame boundary pulse
   input  wire logic          rsp_nak,     // target answered nak
   input  wire logic          rsp_other,   // target answered otherwise
   output logic               timeout,     // halt request pulse
   output logic [CW-1:0]      frame_count  // consecutive nak frames
);

   logic          streak_r;
   logic          fired_r;
   logic          timeout_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic [4:0]    m_eff;
   logic [CW-1:0] limit_frames;
   logic          over_limit;

   // ==========================================
   // limit decode
   // RULE13 two to m minus one
   assign m_eff        = (limit_m > `USBEP_NAK_FRAME_LIMIT_MAX) ? `USBEP_NAK_FRAME_LIMIT_MAX : limit_m;
   assign limit_frames = CW'(1) << (m_eff - 5'h01);
   assign over_limit   = count_r > limit_frames;
   // RULE17 restart on other answer
   assign count_nxt    = (rsp_other || !enable) ? '0 :
                         (frame_start && (streak_r || rsp_nak) && !(&count_r)) ? count_r + CW'(1) :
                         count_r;
   assign timeout      = timeout_r;
   assign frame_count  = count_r;

   // streak and counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         streak_r <= 1'b0;
         count_r  <= '0;
      end else begin
         streak_r <= rsp_other ? 1'b0 : (rsp_nak ? 1'b1 : streak_r);
         count_r  <= count_nxt;
      end
   end

   // RULE14 one halt per streak
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_r <= 1'b0;
         fired_r   <= 1'b0;
      end else begin
         timeout_r <= enable && !fired_r && !timeout_r && over_limit && !rsp_other;
         fired_r   <= (rsp_other || !enable) ? 1'b0 : (fired_r || timeout_r);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_nak_halt_cause: assert property ( // RULE14
      timeout |-> $past(over_limit) && $past(limit_m) >= `USBEP_NAK_FRAME_LIMIT_MIN)
      else $error("nak timeout without exceeding limit");
   a_nak_off_small: assert property ( // RULE15
      (limit_m < `USBEP_NAK_FRAME_LIMIT_MIN) [*2] |-> !timeout)
      else $error("nak timeout fired while disabled");
   a_nak_restart_zero: assert property ( // RULE17
      rsp_other |=> count_r == '0)
      else $error("nak frame count not restarted");
   a_nak_one_pulse: assert property ( // RULE14
      timeout |=> !timeout)
      else $error("nak timeout longer than one cycle");

endmodule

// ==== rtl/usbep_irq.sv ====
`timescale 1ns/1ps
`include "usbep_defs.svh"

module usbep_irq #(
   parameter int N = `USBEP_INT_COUNT
) (
   input  wire logic          pclk,      // system clock
   input  wire logic          presetn,   // async reset, low
   input  wire logic [N-1:0]  ev_set,    // event pulses
   input  wire logic [N-1:0]  ev_clr,    // write one to clear
   input  wire logic          en_we,     // enable register write
   input  wire logic [N-1:0]  en_wdata,  // enable write data
   output logic [N-1:0]       status,    // sticky status
   output logic [N-1:0]       enable,    // enable register
   output logic               irq        // level interrupt
);

   logic [N-1:0] status_r;
   logic [N-1:0] enable_r;

   // ==========================================
   // sticky bits, set wins over clear
   for (genvar i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            status_r[i] <= 1'b0;
         end else if (ev_set[i]) begin
            status_r[i] <= 1'b1;
         end else if (ev_clr[i]) begin
            status_r[i] <= 1'b0;
         end
      end
   end

   // enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_r <= '0;
      end else if (en_we) begin
         enable_r <= en_wdata;
      end
   end

   assign status = status_r;
   assign enable = enable_r;
   assign irq    = |(status_r & enable_r);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_irq_set_wins: assert property (
      ev_set[0] |=> status_r[0])
      else $error("sticky bit lost on set");

endmodule

// ==== rtl/usbep_ep0_ctrl.sv ====
// Functional notes
// RULE1: toggle write enable bit arms one toggle write, then clears itself
// RULE2: reading toggle bit in host mode returns live endpoint 0 data toggle
// RULE3: toggle writes ignored unless enable already set; otherwise value stored
// RULE4: software overwrites toggle only to reset endpoint 0
// RULE5: flush bit drops next packet, resets pointer, clears ready flags
// RULE6: flush bit clears itself after flush; writing zero does nothing
// RULE7: software flushes only while transmit or receive ready is set
// RULE8: device mode high control byte has flush only; bits 7:1 read zero
// RULE9: read-only 7-bit received byte count tracks fifo contents
// RULE10: software trusts byte count only while receive ready is set
// RULE11: speed field bits 7:6, 2 full, 3 low, 0 and 1 reserved
// RULE12: software programs target speed before endpoint 0 host traffic
// RULE13: nak limit m in 2..16 means two to m minus one frames
// RULE14: host mode halts endpoint 0 after too many nak frames
// RULE15: nak limit 0 or 1 disables the nak timeout
// RULE16: nak limit is a 5-bit field at 4:0, upper bits reserved
// RULE17: any non-nak answer restarts the nak frame counter
`timescale 1ns/1ps
`include "usbep_defs.svh"

module usbep_ep0_ctrl #(
   parameter int CW = 17
) (
   input  wire logic          pclk,             // system clock, 40 MHz
   input  wire logic          presetn,          // async reset, low
   input  wire logic          psel,             // apb select
   input  wire logic          penable,          // apb access phase
   input  wire logic          pwrite,           // apb direction
   input  wire logic [11:0]   paddr,            // apb byte address
   input  wire logic [31:0]   pwdata,           // apb write data
   output logic [31:0]        prdata,           // apb read data
   output logic               pready,           // apb ready
   output logic               pslverr,          // apb error
   input  wire logic          host_mode,        // controller acts as host
   input  wire logic          frame_start,      // frame boundary pulse
   input  wire logic          rsp_nak,          // ep0 target answered nak
   input  wire logic          rsp_other,        // ep0 target answered otherwise
   input  wire logic          toggle_flip,      // ep0 transaction completed
   input  wire logic [6:0]    rx_fifo_count,    // bytes in ep0 fifo
   output logic               ep0_data_toggle,  // current data toggle
   output logic               ep0_fifo_flush,   // flush pulse to fifo
   output logic [1:0]         ep0_target_speed, // speed code to link
   output logic               ep0_speed_low,    // target is low speed
   output logic               ep0_halted,       // ep0 halted by nak timeout
   output logic               irq               // level interrupt
);

   // ==========================================
   // state
   logic          toggle_r;
   logic          twe_r;
   logic          flush_r;
   logic          flush_pulse_r;
   logic [6:0]    count_r;
   logic [1:0]    speed_r;
   logic [4:0]    nak_frame_limit_r;
   logic [31:0]   prdata_r;

   // ==========================================
   // apb decode
   logic          setup_ph;
   logic          wr_acc;
   logic          rd_setup;
   logic          word_ok;
   logic          sel_csrh0;
   logic          sel_count0;
   logic          sel_type0;
   logic          sel_nak_frame_limit;
   logic          sel_istat;
   logic          sel_iclr;
   logic          sel_ien;
   logic          addr_hit;

   // phase and address match
   assign setup_ph   = psel && !penable;
   assign wr_acc     = psel && penable && pwrite;
   assign rd_setup   = setup_ph && !pwrite;
   assign word_ok    = paddr[1:0] == 2'h0;
   assign sel_csrh0  = word_ok && paddr[11:2] == `USBEP_IDX_CSRH0;
   assign sel_count0 = word_ok && paddr[11:2] == `USBEP_IDX_COUNT0;
   assign sel_type0  = word_ok && paddr[11:2] == `USBEP_IDX_TYPE0;
   assign sel_nak_frame_limit = word_ok && paddr[11:2] == `USBEP_IDX_NAK_FRAME_LIMIT;
   assign sel_istat  = word_ok && paddr[11:2] == `USBEP_IDX_INT_STAT;
   assign sel_iclr   = word_ok && paddr[11:2] == `USBEP_IDX_INT_CLR;
   assign sel_ien    = word_ok && paddr[11:2] == `USBEP_IDX_INT_EN;
   assign addr_hit   = sel_csrh0 | sel_count0 | sel_type0 | sel_nak_frame_limit |
                       sel_istat | sel_iclr | sel_ien;

   // zero wait, error on unmapped address
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   assign prdata  = prdata_r;

   // ==========================================
   // write strobes
   logic          wr_csrh0;
   logic          wr_type0;
   logic          wr_nak_frame_limit;
   logic          wr_iclr;
   logic          wr_ien;
   logic          twe_set;
   logic          toggle_load;
   logic          flush_req;

   assign wr_csrh0    = wr_acc && sel_csrh0;
   assign wr_type0    = wr_acc && sel_type0;
   assign wr_nak_frame_limit   = wr_acc && sel_nak_frame_limit;
   assign wr_iclr     = wr_acc && sel_iclr;
   assign wr_ien      = wr_acc && sel_ien;
   // RULE1 arm only in host mode
   assign twe_set     = wr_csrh0 && host_mode && pwdata[`USBEP_CSRH0_TWE];
   // RULE3 enable must already be set
   assign toggle_load = wr_csrh0 && host_mode && twe_r;
   // RULE6 only a one starts a flush
   assign flush_req   = wr_csrh0 && pwdata[`USBEP_CSRH0_FLUSH];

   // ==========================================
   // data toggle and its write enable
   logic          toggle_nxt;
   logic          twe_nxt;

   // RULE3 software write beats link flip
   assign toggle_nxt = toggle_load ? pwdata[`USBEP_CSRH0_TOGGLE] :
                       toggle_flip ? !toggle_r : toggle_r;
   // RULE1 self clear after the stored write
   assign twe_nxt    = toggle_load ? 1'b0 : (twe_set ? 1'b1 : twe_r);

   // toggle registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_r <= 1'b0;
         twe_r    <= 1'b0;
      end else begin
         toggle_r <= toggle_nxt;
         twe_r    <= twe_nxt;
      end
   end

   assign ep0_data_toggle = toggle_r;

   // ==========================================
   // fifo flush
   // RULE5 flush pulse clears pointer and ready flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_r       <= 1'b0;
         flush_pulse_r <= 1'b0;
      end else begin
         flush_r       <= flush_req;
         flush_pulse_r <= flush_r;
      end
   end

   assign ep0_fifo_flush = flush_r;

   // ==========================================
   // byte count, speed, nak limit
   // RULE9 count tracks fifo contents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= `USBEP_RST_COUNT;
      end else begin
         count_r <= rx_fifo_count;
      end
   end

   // speed and nak limit registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         speed_r  <= `USBEP_RST_SPEED;
         nak_frame_limit_r <= `USBEP_RST_NAK_FRAME_LIMIT;
      end else begin
         if (wr_type0) begin
            speed_r <= pwdata[`USBEP_SPEED_MSB:`USBEP_SPEED_LSB];
         end
         // RULE16 five bit limit
         if (wr_nak_frame_limit) begin
            nak_frame_limit_r <= pwdata[`USBEP_NAK_FRAME_LIMIT_MSB:0];
         end
      end
   end

   // RULE11 speed code to the link
   assign ep0_target_speed = speed_r;
   assign ep0_speed_low    = speed_r == usbep_pkg::USBEP_SPEED_LOW;

   // ==========================================
   // nak timeout
   logic          nak_enable;
   logic          nak_timeout;

   // RULE15 limit below two disables
   assign nak_enable = host_mode && nak_frame_limit_r >= `USBEP_NAK_FRAME_LIMIT_MIN;

   usbep_nak_timer #(
      .CW          (CW)
   ) u_nak (
      .pclk        (pclk),
      .presetn     (presetn),
      .enable      (nak_enable),
      .limit_m     (nak_frame_limit_r),
      .frame_start (frame_start),
      .rsp_nak     (rsp_nak),
      .rsp_other   (rsp_other),
      .timeout     (nak_timeout),
      .frame_count ()
   );

   // ==========================================
   // interrupt status, clear, enable
   logic [`USBEP_INT_COUNT-1:0] ev_set;
   logic [`USBEP_INT_COUNT-1:0] ev_clr;
   logic [`USBEP_INT_COUNT-1:0] int_status;
   logic [`USBEP_INT_COUNT-1:0] int_enable;

   assign ev_set = {flush_pulse_r, nak_timeout};
   assign ev_clr = wr_iclr ? pwdata[`USBEP_INT_COUNT-1:0] : '0;

   usbep_irq #(
      .N        (`USBEP_INT_COUNT)
   ) u_irq (
      .pclk     (pclk),
      .presetn  (presetn),
      .ev_set   (ev_set),
      .ev_clr   (ev_clr),
      .en_we    (wr_ien),
      .en_wdata (pwdata[`USBEP_INT_COUNT-1:0]),
      .status   (int_status),
      .enable   (int_enable),
      .irq      (irq)
   );

   // RULE14 halt follows the sticky timeout bit
   assign ep0_halted = int_status[`USBEP_INT_NAK_TO];

   // ==========================================
   // read data mux
   logic [7:0]    rd_csrh0;
   logic [31:0]   rd_word;

   // RULE2 live toggle in host mode
   // RULE8 device mode shows flush only
   assign rd_csrh0 = host_mode ? {5'h00, twe_r, toggle_r, flush_r} : {7'h00, flush_r};
   assign rd_word  = sel_csrh0  ? {24'h000000, rd_csrh0} :
                     sel_count0 ? {25'h0000000, count_r} :
                     sel_type0  ? {24'h000000, speed_r, 6'h00} :
                     sel_nak_frame_limit ? {27'h0000000, nak_frame_limit_r} :
                     sel_istat  ? {30'h00000000, int_status} :
                     sel_ien    ? {30'h00000000, int_enable} :
                     32'h00000000;

   // capture read data in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (rd_setup) begin
         prdata_r <= rd_word;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_armed_write;
      twe_r && wr_csrh0 && host_mode;
   endsequence

   sequence s_flush_write;
      wr_csrh0 && pwdata[`USBEP_CSRH0_FLUSH];
   endsequence

   sequence s_csrh0_read(logic hm);
      rd_setup && sel_csrh0 && host_mode == hm;
   endsequence

   a_twe_self_clear: assert property ( // RULE1
      s_armed_write |=> !twe_r)
      else $error("toggle write enable did not clear");

   a_toggle_readback: assert property ( // RULE2
      s_csrh0_read(1'b1) |=> prdata_r[`USBEP_CSRH0_TOGGLE] == $past(toggle_r))
      else $error("read toggle differs from live toggle");

   a_toggle_locked: assert property ( // RULE3
      !twe_r && !toggle_flip |=> toggle_r == $past(toggle_r))
      else $error("toggle changed without enable or flip");

   a_toggle_loaded: assert property ( // RULE3
      s_armed_write |=> toggle_r == $past(pwdata[`USBEP_CSRH0_TOGGLE]))
      else $error("armed toggle write not stored");

   a_flush_steps: assert property ( // RULE5
      s_flush_write |=> ep0_fifo_flush ##1 !ep0_fifo_flush ##1 int_status[`USBEP_INT_FLUSH])
      else $error("flush pulse or flush event missing");

   a_flush_zero_noop: assert property ( // RULE6
      !(wr_csrh0 && pwdata[`USBEP_CSRH0_FLUSH]) |=> !flush_r)
      else $error("flush set without a written one");

   a_device_reserved: assert property ( // RULE8
      s_csrh0_read(1'b0) |=> prdata_r[7:1] == 7'h00)
      else $error("device mode reserved bits not zero");

   a_count_follows: assert property ( // RULE9
      ##1 count_r == $past(rx_fifo_count))
      else $error("byte count does not follow fifo");

   a_speed_layout: assert property ( // RULE11
      rd_setup && sel_type0 |=> prdata_r[7:6] == $past(speed_r) && prdata_r[5:0] == 6'h00)
      else $error("speed field misplaced");

   a_nak_frame_limit_width: assert property ( // RULE16
      rd_setup && sel_nak_frame_limit |=> prdata_r[31:5] == 27'h0000000)
      else $error("nak limit upper bits not zero");

   a_halt_on_timeout: assert property ( // RULE14
      nak_timeout |=> ep0_halted && (irq || !int_enable[`USBEP_INT_NAK_TO]))
      else $error("timeout did not halt endpoint");

   a_halt_sticky: assert property ( // RULE14
      ep0_halted && !(wr_iclr && pwdata[`USBEP_INT_NAK_TO]) |=> ep0_halted)
      else $error("halt dropped without a clear");

   a_twe_arms: assert property ( // RULE1
      wr_csrh0 && host_mode && !twe_r && pwdata[`USBEP_CSRH0_TWE] |=> twe_r)
      else $error("toggle write enable not armed");

   a_device_no_arm: assert property ( // RULE8
      wr_csrh0 && !host_mode |=> twe_r == $past(twe_r))
      else $error("device mode write changed toggle enable");

   a_speed_store: assert property ( // RULE11
      wr_type0 |=> speed_r == $past(pwdata[`USBEP_SPEED_MSB:`USBEP_SPEED_LSB]))
      else $error("speed field not stored");

   a_nak_frame_limit_store: assert property ( // RULE16
      wr_nak_frame_limit |=> nak_frame_limit_r == $past(pwdata[`USBEP_NAK_FRAME_LIMIT_MSB:0]))
      else $error("nak limit not stored");

endmodule

// ==== testbench/usbep_link_model.sv ====
`timescale 1ns/1ps
// ==========================================
// far side of the ep0 link: frames, answers, fifo
module usbep_link_model (
   input  wire logic       pclk,         // system clock
   input  wire logic       flush,        // flush pulse from block
   output logic            frame_start,  // frame boundary pulse
   output logic            rsp_nak,      // nak answer pulse
   output logic            rsp_other,    // other answer pulse
   output logic            toggle_flip,  // transaction done pulse
   output logic [6:0]      rx_count      // bytes held in fifo
);
   logic rx_ready;                       // packet waiting in fifo

   initial begin
      frame_start = 1'b0;
      rsp_nak = 1'b0;
      rsp_other = 1'b0;
      toggle_flip = 1'b0;
      rx_count = 7'h00;
      rx_ready = 1'b0;
   end

   // fifo drops its packet and pointer on flush
   always @(posedge pclk) begin
      if (flush === 1'b1) begin
         rx_count <= 7'h00;
         rx_ready <= 1'b0;
      end
   end

   // count only carries bytes while a packet waits
   task automatic load(input logic [6:0] n);
      @(posedge pclk);
      rx_count <= n;
      rx_ready <= 1'b1;
   endtask

   // frames in which the target keeps answering nak
   task automatic naks(input int n);
      repeat (n) begin
         @(posedge pclk);
         frame_start <= 1'b1;
         rsp_nak <= 1'b1;
         @(posedge pclk);
         frame_start <= 1'b0;
         rsp_nak <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask

   // one non-nak answer or one finished transaction
   task automatic pulse(input logic other);
      @(posedge pclk);
      rsp_other <= other;
      toggle_flip <= !other;
      @(posedge pclk);
      rsp_other <= 1'b0;
      toggle_flip <= 1'b0;
   endtask
endmodule

// ==== testbench/test_usb_endpoint0_control_status.sv ====
`timescale 1ns/1ps
`include "usbep_defs.svh"
// ==========================================
// bench top for endpoint 0 control and status
module test_usb_endpoint0_control_status;
   localparam logic [11:0] A_CSR = {`USBEP_IDX_CSRH0, 2'h0};
   localparam logic [11:0] A_CNT = {`USBEP_IDX_COUNT0, 2'h0};
   localparam logic [11:0] A_SPD = {`USBEP_IDX_TYPE0, 2'h0};
   localparam logic [11:0] A_NAK = {`USBEP_IDX_NAK_FRAME_LIMIT, 2'h0};
   localparam logic [11:0] A_STA = {`USBEP_IDX_INT_STAT, 2'h0};
   localparam logic [11:0] A_CLR = {`USBEP_IDX_INT_CLR, 2'h0};
   localparam logic [11:0] A_EN  = {`USBEP_IDX_INT_EN, 2'h0};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        host_mode, fst, nak, oth, flip, tgl, flush, slow, halted, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0]  cnt;
   logic [1:0]  spd;
   int          error_cnt, checks;

   usbep_ep0_ctrl usbep_ep0_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_mode(host_mode), .frame_start(fst), .rsp_nak(nak), .rsp_other(oth),
      .toggle_flip(flip), .rx_fifo_count(cnt), .ep0_data_toggle(tgl), .ep0_fifo_flush(flush),
      .ep0_target_speed(spd), .ep0_speed_low(slow), .ep0_halted(halted), .irq(irq));
   usbep_link_model usbep_link_model_i (.pclk(pclk), .flush(flush), .frame_start(fst), .rsp_nak(nak),
      .rsp_other(oth), .toggle_flip(flip), .rx_count(cnt));

   // ==========================================
   // clock, verdict, compares, bus cycles
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic summarize;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // setup, then access held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         error_cnt++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask

   // let a nak frame's timeout and status land
   task automatic settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask

   // ==========================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      host_mode = 1'b0;
      error_cnt = 0;
      checks = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_CSR, 32'h0000_0000);
      rdc(A_CNT, 32'h0000_0000);
      rdc(A_SPD, 32'h0000_0000);
      rdc(A_NAK, 32'h0000_0000);
      rdc(A_EN, 32'h0000_0000);
      chk1(halted | irq | flush | tgl, 1'b0);
      rdc(12'h000, 32'h0000_0000);
      chk1(err, 1'b1);
      apb(1'b1, A_SPD + 12'h001, 32'h0000_00C0);
      chk1(err, 1'b1);
      rdc(A_SPD, 32'h0000_0000);
      // every speed code, reserved low bits dropped
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, A_SPD, {24'h0, c[1:0], 6'h3F});
         rdc(A_SPD, {24'h0, c[1:0], 6'h00});
         chk({30'h0, spd}, {30'h0, c[1:0]});
         chk1(slow, c == 3);
      end
      apb(1'b1, A_NAK, 32'h0000_00FF);
      rdc(A_NAK, 32'h0000_001F);
      usbep_link_model_i.load(7'h5A);
      rdc(A_CNT, 32'h0000_005A);
      usbep_link_model_i.load(7'h7F);
      apb(1'b1, A_CNT, 32'h0000_0000);
      rdc(A_CNT, 32'h0000_007F);
      // flush only with a packet waiting; zero write does nothing
      apb(1'b1, A_CSR, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      chk1(flush, 1'b0);
      apb(1'b1, A_CSR, 32'h0000_0001);
      #1 chk1(flush, 1'b1);
      @(posedge pclk);
      #1 chk1(flush, 1'b0);
      rdc(A_CSR, 32'h0000_0000);
      rdc(A_CNT, 32'h0000_0000);
      rdc(A_STA, 32'h0000_0002);
      chk1(irq, 1'b0);
      apb(1'b1, A_EN, 32'h0000_0003);
      #1 chk1(irq, 1'b1);
      apb(1'b1, A_CLR, 32'h0000_0002);
      #1 chk1(irq, 1'b0);
      rdc(A_STA, 32'h0000_0000);
      rdc(A_CLR, 32'h0000_0000);
      rdc(A_EN, 32'h0000_0003);
      // host toggle: ignored unless armed, arm used once
      @(posedge pclk);
      host_mode <= 1'b1;
      apb(1'b1, A_CSR, 32'h0000_0002);
      rdc(A_CSR, 32'h0000_0000);
      apb(1'b1, A_CSR, 32'h0000_0004);
      apb(1'b1, A_CSR, 32'h0000_0002);
      rdc(A_CSR, 32'h0000_0002);
      apb(1'b1, A_CSR, 32'h0000_0000);
      rdc(A_CSR, 32'h0000_0002);
      chk1(tgl, 1'b1);
      @(posedge pclk);
      host_mode <= 1'b0;
      apb(1'b1, A_CSR, 32'h0000_0004);
      apb(1'b1, A_CSR, 32'h0000_0000);
      rdc(A_CSR, 32'h0000_0000);
      chk1(tgl, 1'b1);
      @(posedge pclk);
      host_mode <= 1'b1;
      usbep_link_model_i.pulse(1'b0);
      rdc(A_CSR, 32'h0000_0000);
      // nak timeout at two limits, cleared after each halt
      apb(1'b1, A_SPD, 32'h0000_0080);
      for (int m = 2; m <= 3; m++) begin
         apb(1'b1, A_NAK, 32'(m));
         usbep_link_model_i.pulse(1'b1);
         usbep_link_model_i.naks(1 << (m - 1));
         settle();
         chk1(halted, 1'b0);
         usbep_link_model_i.naks(1);
         settle();
         chk1(halted, 1'b1);
         chk1(irq, 1'b1);
         rdc(A_STA, 32'h0000_0001);
         apb(1'b1, A_CLR, 32'h0000_0001);
         #1 chk1(halted, 1'b0);
      end
      usbep_link_model_i.pulse(1'b1);
      usbep_link_model_i.naks(3);
      usbep_link_model_i.pulse(1'b1);
      usbep_link_model_i.naks(3);
      settle();
      chk1(halted, 1'b0);
      for (int m = 0; m <= 1; m++) begin
         apb(1'b1, A_NAK, 32'(m));
         usbep_link_model_i.naks(8);
         settle();
         chk1(halted, 1'b0);
      end
      apb(1'b1, A_NAK, 32'h0000_0002);
      @(posedge pclk);
      host_mode <= 1'b0;
      usbep_link_model_i.pulse(1'b1);
      usbep_link_model_i.naks(8);
      settle();
      chk1(halted, 1'b0);
      // mid-run reset returns registers to their reset values
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_SPD, 32'h0000_0000);
      rdc(A_NAK, 32'h0000_0000);
      rdc(A_EN, 32'h0000_0000);
      summarize();
   end
endmodule
